// ==== rtl/pmcs_defs.svh ====
// pmcs_defs.svh: constants for the power mode clock switcher
// assumes inclusion by bare name from package and modules
// Summary of operation
// - switch takes two old-clock ticks then three new-clock ticks
// - primary running is control bit 3, secondary running is control b bit 6
// - each sleep takes idle and deep-sleep enables as they stand then
// - select 01 moves to secondary, stops primary, flips running flags
// - select 01 with secondary oscillator disabled does not switch
// - secondary enabled but not oscillating holds device clocks off
// - secondary to primary keeps secondary clock until primary ready
// - select 11 moves to internal oscillator, stops primary, clears flag
// - internal to primary waits for primary ready; internal rc may run on
// - sleep with idle clear stops oscillator; clears status flags unless deep sleep enable set
// - sleep entry does no switch; rc and secondary may keep running
// - sleep wake waits for selected source, or runs from internal meanwhile
// - sleep with idle set gates cpu only; status flags unchanged
// - idle exits on interrupt, watchdog or reset after cpu ready delay
// - watchdog timeout in idle or non-deep sleep wakes into selected run mode
// - primary idle wake clocks cpu from primary after ready delay
// - secondary idle entry does no switch; primary stays stopped, secondary flag stays set
// - sleep toward secondary idle with oscillator disabled is ignored
// - secondary idle wake resumes cpu on secondary after ready delay
// - after reset start in primary run with primary flag set
// - idle enable at bit 7, source select at bits 1:0
// - deep sleep enable self-clears two instruction cycles after set
`ifndef PMCS_DEFS_SVH
`define PMCS_DEFS_SVH
`define PMCS_ADDR_OSC_CTRL   12'h000
`define PMCS_ADDR_OSC_CTRL_B 12'h004
`define PMCS_ADDR_DS_CTRL    12'h008
`define PMCS_ADDR_SLEEP      12'h00C
`define PMCS_ADDR_OSC_STAT   12'h010
`define PMCS_BIT_IDLE        7
`define PMCS_BIT_PRIMARY_RUN     3
`define PMCS_BIT_SECONDARY_RUN     6
`define PMCS_BIT_SEC_EN      0
`define PMCS_BIT_TWO_SPEED   1
`define PMCS_BIT_FAIL_SAFE_CLOCK_MONITOR        2
`define PMCS_BIT_WDT_EN      3
`define PMCS_BIT_DEEP_SLEEP_ENABLE        7
`define PMCS_SEL_LSB         0
`define PMCS_SEL_MSB         1
`define PMCS_SEL_PRI         2'h0
`define PMCS_SEL_SEC         2'h1
`define PMCS_SEL_RC          2'h3
`define PMCS_OLD_TICKS       3'h2
`define PMCS_NEW_TICKS       3'h3
`define PMCS_DEEP_SLEEP_ENABLE_LIFE       2'h2
`define PMCS_READY_DELAY     16
`endif

// ==== rtl/pmcs_pkg.sv ====
// pmcs_pkg.sv: types of the power mode clock switcher
// assumes pmcs_defs.svh alongside
`include "pmcs_defs.svh"
package pmcs_pkg;
  typedef enum logic [6:0] {
    PMCS_RUN      = 7'h01,
    PMCS_SW_OLD   = 7'h02,
    PMCS_SW_NEW   = 7'h04,
    PMCS_IDLE     = 7'h08,
    PMCS_SLEEP    = 7'h10,
    PMCS_WAKE_SRC = 7'h20,
    PMCS_WAKE_DLY = 7'h40
  } pmcs_state_t;
endpackage

// ==== rtl/pmcs_tick_sync.sv ====
// pmcs_tick_sync.sv: two-flop synchroniser plus rising edge pulse
// assumes one clock; input comes from an oscillator domain or a pin
`timescale 1ns/1ps
`default_nettype none
module pmcs_tick_sync (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);
  logic [2:0] sh_reg;
  // first flop feeds only the second one
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sh_reg <= 3'h0;
    end else begin
      sh_reg <= {sh_reg[1:0], async_in};
    end
  end
  assign level_out = sh_reg[1];
  assign rise_out  = sh_reg[1] & ~sh_reg[2];
endmodule // pmcs_tick_sync
`default_nettype wire

// ==== rtl/pmcs_switcher.sv ====
// pmcs_switcher.sv: power mode and clock source controller with apb slave
// assumes oscillator clocks arrive as plain asynchronous pins sampled here
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pmcs_defs.svh"
module pmcs_switcher
  import pmcs_pkg::*;
#(
  parameter int unsigned READY_DELAY = `PMCS_READY_DELAY
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleep_exec,
  input  wire logic        instr_tick,
  input  wire logic        wake_irq,
  input  wire logic        wake_wdt,
  input  wire logic        pri_osc_clk,
  input  wire logic        pri_osc_ready,
  input  wire logic        sec_osc_clk,
  input  wire logic        sec_osc_running,
  input  wire logic        rc_osc_clk,
  output logic [1:0]       clk_src_sel,
  output logic             dev_clk_en,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             pri_osc_on,
  output logic             sec_osc_on,
  output logic             rc_osc_on,
  output logic             deep_sleep_req
);
  localparam int unsigned DW = $clog2(READY_DELAY + 1);

  typedef struct packed {
    pmcs_state_t st;
    logic        idle_enable;
    logic [1:0]  source_select;
    logic        sec_en;
    logic        two_speed;
    logic        fail_safe_clock_monitor;
    logic        wdt_en;
    logic        deep_sleep_enable;
    logic [1:0]  deep_sleep_enable_age;
    logic        primary_running_flag;
    logic        secondary_running_flag;
    logic [1:0]  cur_src;
    logic [1:0]  tgt_src;
    logic [2:0]  tick_cnt;
    logic [DW-1:0] dly_cnt;
    logic        sleeping;
    logic        deep;
    logic        pri_keep;
    logic [31:0] rdata;
  } pmcs_regs_t;

  pmcs_regs_t s_reg;
  pmcs_regs_t s_next;

  logic pri_rise, sec_rise, rc_rise;
  logic pri_rdy_s, secondary_run_s;

  pmcs_tick_sync u_pri (.clk_sys(clk_sys), .rstn(rstn),
    .async_in(pri_osc_clk), .level_out(), .rise_out(pri_rise));
  pmcs_tick_sync u_sec (.clk_sys(clk_sys), .rstn(rstn),
    .async_in(sec_osc_clk), .level_out(), .rise_out(sec_rise));
  pmcs_tick_sync u_rc (.clk_sys(clk_sys), .rstn(rstn),
    .async_in(rc_osc_clk), .level_out(), .rise_out(rc_rise));
  pmcs_tick_sync u_prdy (.clk_sys(clk_sys), .rstn(rstn),
    .async_in(pri_osc_ready), .level_out(pri_rdy_s), .rise_out());
  pmcs_tick_sync u_srun (.clk_sys(clk_sys), .rstn(rstn),
    .async_in(sec_osc_running), .level_out(secondary_run_s), .rise_out());

  function automatic logic src_ready(input logic [1:0] src,
                                     input logic pr, input logic sr);
    if (src == `PMCS_SEL_PRI) begin
      src_ready = pr;
    end else if (src == `PMCS_SEL_SEC) begin
      src_ready = sr;
    end else begin
      src_ready = 1'b1;
    end
  endfunction

  function automatic logic src_tick(input logic [1:0] src, input logic p,
                                    input logic s, input logic r);
    if (src == `PMCS_SEL_PRI) begin
      src_tick = p;
    end else if (src == `PMCS_SEL_SEC) begin
      src_tick = s;
    end else begin
      src_tick = r;
    end
  endfunction

  logic setup_wr, acc, wake_ev, old_tick, new_tick, tgt_ok;

  assign acc      = psel & penable;
  assign setup_wr = acc & pwrite;
  assign wake_ev  = wake_irq | wake_wdt;
  assign old_tick = src_tick(s_reg.cur_src, pri_rise, sec_rise, rc_rise);
  assign new_tick = src_tick(s_reg.tgt_src, pri_rise, sec_rise, rc_rise);
  assign tgt_ok   = src_ready(s_reg.tgt_src, pri_rdy_s, secondary_run_s);

  always_comb begin
    s_next = s_reg;
    // deep sleep enable dies two instruction cycles after being set
    if (s_reg.deep_sleep_enable && instr_tick) begin
      if (s_reg.deep_sleep_enable_age == `PMCS_DEEP_SLEEP_ENABLE_LIFE - 2'h1) begin
        s_next.deep_sleep_enable = 1'b0;
        s_next.deep_sleep_enable_age = 2'h0;
      end else begin
        s_next.deep_sleep_enable_age = s_reg.deep_sleep_enable_age + 2'h1;
      end
    end
    // register writes on the apb access phase
    if (setup_wr) begin
      if (paddr == `PMCS_ADDR_OSC_CTRL) begin
        s_next.idle_enable   = pwdata[`PMCS_BIT_IDLE];
        s_next.source_select = pwdata[`PMCS_SEL_MSB:`PMCS_SEL_LSB];
      end else if (paddr == `PMCS_ADDR_OSC_CTRL_B) begin
        s_next.sec_en    = pwdata[`PMCS_BIT_SEC_EN];
        s_next.two_speed = pwdata[`PMCS_BIT_TWO_SPEED];
        s_next.fail_safe_clock_monitor      = pwdata[`PMCS_BIT_FAIL_SAFE_CLOCK_MONITOR];
        s_next.wdt_en    = pwdata[`PMCS_BIT_WDT_EN];
      end else if (paddr == `PMCS_ADDR_DS_CTRL) begin
        s_next.deep_sleep_enable = pwdata[`PMCS_BIT_DEEP_SLEEP_ENABLE];
        s_next.deep_sleep_enable_age = 2'h0;
      end
    end
    s_next.rdata = 32'h0;
    if (paddr == `PMCS_ADDR_OSC_CTRL) begin
      s_next.rdata[`PMCS_BIT_IDLE]    = s_reg.idle_enable;
      s_next.rdata[`PMCS_BIT_PRIMARY_RUN] = s_reg.primary_running_flag;
      s_next.rdata[`PMCS_SEL_MSB:`PMCS_SEL_LSB] = s_reg.source_select;
    end else if (paddr == `PMCS_ADDR_OSC_CTRL_B) begin
      s_next.rdata[`PMCS_BIT_SECONDARY_RUN]   = s_reg.secondary_running_flag;
      s_next.rdata[`PMCS_BIT_SEC_EN]    = s_reg.sec_en;
      s_next.rdata[`PMCS_BIT_TWO_SPEED] = s_reg.two_speed;
      s_next.rdata[`PMCS_BIT_FAIL_SAFE_CLOCK_MONITOR]      = s_reg.fail_safe_clock_monitor;
      s_next.rdata[`PMCS_BIT_WDT_EN]    = s_reg.wdt_en;
    end else if (paddr == `PMCS_ADDR_DS_CTRL) begin
      s_next.rdata[`PMCS_BIT_DEEP_SLEEP_ENABLE] = s_reg.deep_sleep_enable;
    end else if (paddr == `PMCS_ADDR_OSC_STAT) begin
      s_next.rdata[6:0]  = s_reg.st;
      s_next.rdata[9:8]  = s_reg.cur_src;
      s_next.rdata[10]   = s_reg.sleeping;
    end
    case (s_reg.st)
      PMCS_RUN: begin
        if (sleep_exec) begin
          // enables are sampled right here, each sleep on its own
          if (s_reg.deep_sleep_enable && !s_reg.idle_enable) begin
            s_next.deep = 1'b1;
            s_next.sleeping = 1'b1;
            s_next.st = PMCS_SLEEP;
          end else if (!s_reg.idle_enable) begin
            // no switch on the way down, flags drop
            s_next.primary_running_flag = 1'b0;
            s_next.secondary_running_flag = 1'b0;
            s_next.sleeping = 1'b1;
            s_next.st = PMCS_SLEEP;
          end else if (s_reg.source_select == `PMCS_SEL_SEC &&
                       !s_reg.sec_en) begin
            s_next.st = PMCS_RUN;
          end else begin
            s_next.st = PMCS_IDLE;
          end
        end else if (s_reg.source_select != s_reg.cur_src &&
                     !(s_reg.source_select == `PMCS_SEL_SEC &&
                       !s_reg.sec_en)) begin
          s_next.tgt_src = s_reg.source_select;
          s_next.tick_cnt = 3'h0;
          s_next.st = PMCS_SW_OLD;
        end
      end
      PMCS_SW_OLD: begin
        // outgoing clock keeps running until target is ready
        if (s_reg.tgt_src != s_reg.source_select) begin
          s_next.st = PMCS_RUN;
        end else if (old_tick && s_reg.tick_cnt == `PMCS_OLD_TICKS - 3'h1 &&
                     tgt_ok) begin
          s_next.tick_cnt = 3'h0;
          s_next.st = PMCS_SW_NEW;
        end else if (old_tick && s_reg.tick_cnt != `PMCS_OLD_TICKS - 3'h1) begin
          s_next.tick_cnt = s_reg.tick_cnt + 3'h1;
        end
      end
      PMCS_SW_NEW: begin
        // mux is dead between sources, so no runt pulse reaches the core
        if (new_tick && s_reg.tick_cnt == `PMCS_NEW_TICKS - 3'h1) begin
          s_next.cur_src = s_reg.tgt_src;
          s_next.primary_running_flag = (s_reg.tgt_src == `PMCS_SEL_PRI);
          s_next.secondary_running_flag =
            (s_reg.tgt_src == `PMCS_SEL_SEC);
          s_next.st = PMCS_RUN;
        end else if (new_tick) begin
          s_next.tick_cnt = s_reg.tick_cnt + 3'h1;
        end
      end
      PMCS_IDLE: begin
        if (wake_ev) begin
          s_next.dly_cnt = DW'(READY_DELAY);
          s_next.st = PMCS_WAKE_DLY;
        end
      end
      PMCS_SLEEP: begin
        if (wake_ev && !s_reg.deep) begin
          s_next.tgt_src = s_reg.source_select;
          s_next.st = PMCS_WAKE_SRC;
        end
      end
      PMCS_WAKE_SRC: begin
        // selected source, or internal when two-speed or monitor allows it
        if (src_ready(s_reg.tgt_src, pri_rdy_s, secondary_run_s)) begin
          s_next.cur_src = s_reg.tgt_src;
          s_next.sleeping = 1'b0;
          s_next.primary_running_flag = (s_reg.tgt_src == `PMCS_SEL_PRI);
          s_next.secondary_running_flag = (s_reg.tgt_src == `PMCS_SEL_SEC);
          s_next.dly_cnt = DW'(READY_DELAY);
          s_next.st = PMCS_WAKE_DLY;
        end else if (s_reg.two_speed || s_reg.fail_safe_clock_monitor) begin
          s_next.cur_src = `PMCS_SEL_RC;
        end
      end
      PMCS_WAKE_DLY: begin
        // same count for every wake
        if (s_reg.dly_cnt == DW'(0)) begin
          s_next.st = PMCS_RUN;
        end else begin
          s_next.dly_cnt = s_reg.dly_cnt - DW'(1);
        end
      end
      default: s_next.st = PMCS_RUN;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.st <= PMCS_RUN;
      s_reg.cur_src <= `PMCS_SEL_PRI;
      s_reg.tgt_src <= `PMCS_SEL_PRI;
      s_reg.primary_running_flag <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  logic in_sleep, in_idle, in_gap, wake_src, sec_wait;
  // a secondary that has not started yet must not clock anything
  assign sec_wait = (s_reg.st == PMCS_SW_OLD) &
                    (s_reg.tgt_src == `PMCS_SEL_SEC) & ~tgt_ok;
  assign in_sleep = (s_reg.st == PMCS_SLEEP);
  assign in_idle  = (s_reg.st == PMCS_IDLE);
  assign in_gap   = (s_reg.st == PMCS_SW_NEW);
  assign wake_src = (s_reg.st == PMCS_WAKE_SRC);

  assign prdata         = s_reg.rdata;
  assign pready         = acc;
  assign pslverr        = 1'b0;
  assign deep_sleep_req = in_sleep & s_reg.deep;
  assign clk_src_sel    = s_reg.cur_src;
  // device clock stalls while a secondary source has not started
  assign dev_clk_en     = ~in_sleep & ~in_gap & ~sec_wait &
                          ~(wake_src & s_reg.cur_src != `PMCS_SEL_RC |
                            wake_src & ~s_reg.two_speed & ~s_reg.fail_safe_clock_monitor);
  assign periph_clk_en  = dev_clk_en;
  assign cpu_clk_en     = dev_clk_en & ~in_idle &
                          (s_reg.st != PMCS_WAKE_DLY);
  // primary stays up while it or the switch target needs it
  assign pri_osc_on     = ~s_reg.sleeping &
                          (s_reg.cur_src == `PMCS_SEL_PRI |
                           s_reg.tgt_src == `PMCS_SEL_PRI |
                           s_reg.source_select == `PMCS_SEL_PRI) |
                          wake_src & s_reg.tgt_src == `PMCS_SEL_PRI;
  assign sec_osc_on     = s_reg.sec_en;
  // internal rc also runs while it is the switch target, else no new ticks
  assign rc_osc_on      = s_reg.wdt_en | s_reg.fail_safe_clock_monitor |
                          (~s_reg.sleeping &
                           (s_reg.cur_src[`PMCS_SEL_MSB] |
                            s_reg.tgt_src[`PMCS_SEL_MSB])) |
                          wake_src;
endmodule // pmcs_switcher
`default_nettype wire

// ==== bench/pmcs_osc_model.sv ====
// pmcs_osc_model.sv: oscillator side of the clock switcher
// assumes the enables come straight from the switcher outputs
`timescale 1ns/1ps
`default_nettype none
module pmcs_osc_model #(
  parameter int PRI_START = 24,
  parameter int SEC_START = 40
) (
  input  wire logic clk_sys,
  input  wire logic pri_on,
  input  wire logic sec_on,
  input  wire logic rc_on,
  output logic      pri_clk,
  output logic      pri_ready,
  output logic      sec_clk,
  output logic      sec_running,
  output logic      rc_clk
);
  int pri_cnt = 0;
  int sec_cnt = 0;
  int ph = 0;
  always @(posedge clk_sys) begin
    ph <= ph + 1;
    pri_cnt <= pri_on ? pri_cnt + 1 : 0;
    sec_cnt <= sec_on ? sec_cnt + 1 : 0;
  end
  // ready lags enable so a switch to primary must wait
  assign pri_ready = pri_cnt > PRI_START;
  // slow start: no secondary edges until it runs
  assign sec_running = sec_cnt > SEC_START;
  // a stopped oscillator stands still, never a stale phase
  assign pri_clk = pri_ready && ph[1];
  assign sec_clk = sec_running && ph[2];
  assign rc_clk = rc_on && ph[0];
endmodule // pmcs_osc_model
`default_nettype wire

// ==== bench/pmcs_switcher_monitor.sv ====
// pmcs_switcher_monitor.sv: port checker for the clock switcher
// assumes it is bound onto pmcs_switcher, one clock domain
`timescale 1ns/1ps
`default_nettype none
module pmcs_switcher_monitor #(
  parameter int unsigned READY_DELAY = 4
) (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       wake_irq,
  input wire logic       wake_wdt,
  input wire logic       pri_osc_ready,
  input wire logic [1:0] clk_src_sel,
  input wire logic       dev_clk_en,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       pri_osc_on,
  input wire logic       sec_osc_on
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  AST_RESET_PRI: assert property ($rose(rstn) |->
    clk_src_sel == 2'h0 && pri_osc_on && cpu_clk_en)
    else $error("reset did not leave primary run");
  AST_SWITCH_GAP: assert property ($changed(clk_src_sel) |->
    !$past(dev_clk_en)) else $error("source moved without clock gap");
  AST_SEC_PRI_OFF: assert property ($changed(clk_src_sel) &&
    clk_src_sel == 2'h1 |-> !pri_osc_on && sec_osc_on)
    else $error("secondary switch left primary on");
  AST_SEC_NEEDS_EN: assert property (clk_src_sel == 2'h1 |->
    sec_osc_on) else $error("secondary source while disabled");
  AST_RC_PRI_OFF: assert property ($changed(clk_src_sel) &&
    clk_src_sel == 2'h3 |-> !pri_osc_on)
    else $error("internal switch left primary on");
  AST_PRI_READY: assert property ($changed(clk_src_sel) &&
    clk_src_sel == 2'h0 |-> pri_osc_ready && pri_osc_on)
    else $error("switched to primary before ready");
  AST_SLEEP_NO_SWITCH: assert property (!periph_clk_en |->
    $stable(clk_src_sel)) else $error("source switched while asleep");
  AST_SLEEP_CPU_OFF: assert property (!periph_clk_en |->
    !cpu_clk_en) else $error("cpu clocked while asleep");
  AST_IDLE_WAKE_DELAY: assert property ($rose(wake_irq) &&
    periph_clk_en && !cpu_clk_en |=> !cpu_clk_en [*4] ##[1:10] cpu_clk_en)
    else $error("idle wake delay wrong");
  AST_WDT_WAKE: assert property ($rose(wake_wdt) && !cpu_clk_en |->
    ##[1:400] cpu_clk_en) else $error("watchdog did not wake the cpu");
  COV_SEC: cover property ($changed(clk_src_sel) && clk_src_sel == 2'h1);
  COV_IDLE: cover property ($fell(cpu_clk_en) && periph_clk_en);
  COV_SLEEP: cover property ($fell(periph_clk_en));
endmodule // pmcs_switcher_monitor
bind pmcs_switcher pmcs_switcher_monitor #(.READY_DELAY(READY_DELAY)) u_mon (
  .clk_sys(clk_sys), .rstn(rstn), .wake_irq(wake_irq), .wake_wdt(wake_wdt),
  .pri_osc_ready(pri_osc_ready), .clk_src_sel(clk_src_sel),
  .dev_clk_en(dev_clk_en), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .pri_osc_on(pri_osc_on),
  .sec_osc_on(sec_osc_on));
`default_nettype wire

// ==== bench/pmcs_switcher_tb.sv ====
// pmcs_switcher_tb.sv: self-checking bench for the clock switcher
// assumes zero-wait apb and the oscillator model on the far side
`timescale 1ns/1ps
`default_nettype none
`include "pmcs_defs.svh"
module pmcs_switcher_tb;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        slv;
  logic        sleep_exec = 1'b0, instr_tick = 1'b0;
  logic        wake_irq = 1'b0, wake_wdt = 1'b0;
  logic        pready, pslverr, dev_clk_en, cpu_clk_en, periph_clk_en;
  logic        pri_osc_on, sec_osc_on, rc_osc_on, deep_sleep_req;
  logic        pri_osc_clk, pri_osc_ready, sec_osc_clk;
  logic        sec_osc_running, rc_osc_clk;
  logic [1:0]  clk_src_sel;
  int          bad_count = 0, samples_checked = 0, cyc = 0;
  always #4 clk_sys = ~clk_sys;
  pmcs_switcher #(.READY_DELAY(4)) u_dut (.clk_sys(clk_sys), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_exec(sleep_exec), .instr_tick(instr_tick), .wake_irq(wake_irq),
    .wake_wdt(wake_wdt), .pri_osc_clk(pri_osc_clk),
    .pri_osc_ready(pri_osc_ready), .sec_osc_clk(sec_osc_clk),
    .sec_osc_running(sec_osc_running), .rc_osc_clk(rc_osc_clk),
    .clk_src_sel(clk_src_sel), .dev_clk_en(dev_clk_en),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .pri_osc_on(pri_osc_on), .sec_osc_on(sec_osc_on),
    .rc_osc_on(rc_osc_on), .deep_sleep_req(deep_sleep_req));
  pmcs_osc_model u_osc (.clk_sys(clk_sys), .pri_on(pri_osc_on),
    .sec_on(sec_osc_on), .rc_on(rc_osc_on), .pri_clk(pri_osc_clk),
    .pri_ready(pri_osc_ready), .sec_clk(sec_osc_clk),
    .sec_running(sec_osc_running), .rc_clk(rc_osc_clk));
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    // a hang counts as a mismatch and ends the run
    if (cyc == 20000) begin
      bad_count++;
      test_done;
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one transfer, waits for pready; ends one idle cycle later to chain calls
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input string nm, input logic [31:0] m,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, q & m, e);
    chk("slverr", {31'h0, slv}, 32'h0);
  endtask
  task automatic pulse(input int k);
    if (k == 0) sleep_exec <= 1'b1;
    else if (k == 1) wake_irq <= 1'b1;
    else if (k == 2) wake_wdt <= 1'b1;
    else instr_tick <= 1'b1;
    @(posedge clk_sys);
    {sleep_exec, wake_irq, wake_wdt, instr_tick} <= 4'h0;
    @(posedge clk_sys);
  endtask
  // waits for a level, then compares what finally stood there
  task automatic wait_for(input string nm, input int k, input logic [1:0] v,
                          input logic [1:0] e);
    logic [1:0] s;
    s = 2'h0;
    for (int i = 0; i < 600; i++) begin
      @(negedge clk_sys);
      case (k)
        0: s = clk_src_sel;
        1: s = {1'b0, cpu_clk_en};
        2: s = {dev_clk_en, periph_clk_en};
        3: s = {1'b0, pri_osc_on};
        5: s = {1'b0, deep_sleep_req};
        6: s = {1'b0, rc_osc_on};
        default: s = {1'b0, sec_osc_on};
      endcase
      if (s === v) break;
    end
    chk(nm, {30'h0, s}, {30'h0, e});
    @(posedge clk_sys);
  endtask
  task automatic t_reset;
    rd(`PMCS_ADDR_OSC_CTRL, "ctrl", 32'h8B, 32'h08);
    wait_for("src", 0, 2'h0, 2'h0);
    $display("test reset done");
  endtask
  task automatic t_sec_off;
    apb(1'b1, `PMCS_ADDR_OSC_CTRL, 32'h81);
    wait_for("src", 0, 2'h1, 2'h0);
    pulse(0);
    wait_for("cpu", 1, 2'h0, 2'h1);
    $display("test secondary disabled done");
  endtask
  task automatic t_secondary_idle;
    apb(1'b1, `PMCS_ADDR_OSC_CTRL_B, 32'h01);
    wait_for("gap", 2, 2'h0, 2'h0);
    rd(`PMCS_ADDR_OSC_STAT, "state", 32'h7F, 32'h02);
    wait_for("src", 0, 2'h1, 2'h1);
    rd(`PMCS_ADDR_OSC_CTRL, "pri flag", 32'h08, 32'h0);
    rd(`PMCS_ADDR_OSC_CTRL_B, "sec flag", 32'h40, 32'h40);
    wait_for("pri on", 3, 2'h0, 2'h0);
    pulse(0);
    wait_for("cpu", 1, 2'h0, 2'h0);
    wait_for("periph", 2, 2'h3, 2'h3);
    rd(`PMCS_ADDR_OSC_CTRL_B, "sec flag", 32'h40, 32'h40);
    pulse(1);
    wait_for("cpu", 1, 2'h1, 2'h1);
    wait_for("src", 0, 2'h1, 2'h1);
    rd(`PMCS_ADDR_OSC_CTRL, "ctrl", 32'h83, 32'h81);
    $display("test secondary idle done");
  endtask
  task automatic t_sleep;
    apb(1'b1, `PMCS_ADDR_OSC_CTRL, 32'h00);
    wait_for("src", 0, 2'h0, 2'h0);
    wait_for("sec on", 4, 2'h1, 2'h1);
    rd(`PMCS_ADDR_OSC_CTRL_B, "sec flag", 32'h40, 32'h0);
    pulse(0);
    wait_for("periph", 2, 2'h0, 2'h0);
    wait_for("pri on", 3, 2'h0, 2'h0);
    rd(`PMCS_ADDR_OSC_CTRL, "pri flag", 32'h08, 32'h0);
    pulse(2);
    wait_for("cpu", 1, 2'h1, 2'h1);
    rd(`PMCS_ADDR_OSC_CTRL, "pri flag", 32'h08, 32'h08);
    $display("test sleep done");
  endtask
  task automatic t_primary_idle;
    apb(1'b1, `PMCS_ADDR_OSC_CTRL, 32'h03);
    wait_for("src", 0, 2'h3, 2'h3);
    wait_for("rc on", 6, 2'h1, 2'h1);
    rd(`PMCS_ADDR_OSC_CTRL, "pri flag", 32'h08, 32'h0);
    rd(`PMCS_ADDR_OSC_CTRL_B, "sec flag", 32'h40, 32'h0);
    // idle first, then select primary, then sleep
    apb(1'b1, `PMCS_ADDR_OSC_CTRL, 32'h83);
    apb(1'b1, `PMCS_ADDR_OSC_CTRL, 32'h80);
    wait_for("src", 0, 2'h0, 2'h0);
    wait_for("rc on", 6, 2'h0, 2'h0);
    pulse(0);
    wait_for("cpu", 1, 2'h0, 2'h0);
    rd(`PMCS_ADDR_OSC_CTRL, "pri flag", 32'h08, 32'h08);
    pulse(1);
    wait_for("cpu", 1, 2'h1, 2'h1);
    rd(`PMCS_ADDR_OSC_CTRL, "ctrl", 32'h8B, 32'h88);
    $display("test primary idle done");
  endtask
  task automatic t_deep;
    apb(1'b1, `PMCS_ADDR_DS_CTRL, 32'h80);
    rd(`PMCS_ADDR_DS_CTRL, "deep en", 32'h80, 32'h80);
    pulse(3);
    pulse(3);
    rd(`PMCS_ADDR_DS_CTRL, "deep en", 32'h80, 32'h0);
    // sleep right after setting the enable goes deep; only reset leaves it
    apb(1'b1, `PMCS_ADDR_OSC_CTRL, 32'h00);
    apb(1'b1, `PMCS_ADDR_DS_CTRL, 32'h80);
    pulse(0);
    wait_for("deep", 5, 2'h1, 2'h1);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd(`PMCS_ADDR_OSC_CTRL, "ctrl", 32'h8B, 32'h08);
    wait_for("deep", 5, 2'h0, 2'h0);
    $display("test deep enable done");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_sec_off;
    t_secondary_idle;
    t_sleep;
    t_primary_idle;
    t_deep;
    test_done;
  end
endmodule // pmcs_switcher_tb
`default_nettype wire
